// File: common/alc_cfg.svh
// Purpose: Offsets, field positions and reset values of the link control
// Assumes: Byte addresses on a 32-bit AXI4-Lite register bus
// Notes: Included by the package and by the design files
`ifndef ALC_CFG_SVH
`define ALC_CFG_SVH

// Register byte offsets
`define ALC_OFF_ENABLE 8'h00
`define ALC_OFF_DISABLE 8'h04
`define ALC_OFF_READY 8'h08
`define ALC_OFF_IRQ_STATUS 8'h0C
`define ALC_OFF_IRQ_MASK 8'h10

// Control field positions of the enable register; the disable register uses only warm reset and receive select
`define ALC_BIT_COLD_RELEASE 0
`define ALC_BIT_POWER_DOWN 1
`define ALC_BIT_WAKE_ENABLE 2
`define ALC_BIT_WARM_RESET 3
`define ALC_BIT_RX_SELECT 4
`define ALC_BIT_READY_CLEAR 5

// Interrupt status and mask field positions
`define ALC_IRQ_READY0 0
`define ALC_IRQ_READY1 1
`define ALC_IRQ_WAKE 2

// Reset values
`define ALC_CTRL_RESET 5'h00
`define ALC_IRQ_RESET 3'h0

// Link framing: bits per frame and bits of the tag slot
`define ALC_FRAME_BITS 256
`define ALC_TAG_BITS 16

// AXI responses
`define ALC_RESP_OKAY 2'h0
`define ALC_RESP_SLVERR 2'h2

`endif

// File: common/alc_pkg.sv
// Purpose: Types shared by the link control design
// Assumes: Constants come from alc_cfg.svh
// Notes: Control fields kept in one packed struct
package alc_pkg;
   `include "alc_cfg.svh"

   typedef struct packed {
      logic rx_select;
      logic warm_reset;
      logic wake_enable;
      logic power_down;
      logic cold_release;
   } alc_ctrl_t;

   typedef logic [1:0] alc_resp_t;
endpackage : alc_pkg

// File: verilog/alc_link_rx.sv
// Purpose: Samples the link bit clock and codec data, frames the link
// Assumes: Bit clock far slower than aclk (125 ns against 8 ns)
// Notes: Frame timing only; slot payloads are handled elsewhere
`timescale 1ns/100ps
`include "alc_cfg.svh"
module alc_link_rx #(
   parameter int FRAME_BITS = `ALC_FRAME_BITS,
   parameter int TAG_BITS = `ALC_TAG_BITS
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Link pins, asynchronous to aclk
   input wire logic bit_clk,
   input wire logic [1:0] sdin,
   // To the controller
   output logic frame_sync,
   output logic [1:0] ready_seen,
   output logic sdin_any
);
   import alc_pkg::*;

   localparam int CW = $clog2(FRAME_BITS);

   logic [2:0] clk_meta;
   logic [1:0] sdin_meta;
   logic [1:0] sdin_sync;
   logic [CW-1:0] bit_cnt;
   logic tag_pending;

   // Second stage and a history stage; the first stage feeds nothing else
   wire bit_rise = clk_meta[1] & ~clk_meta[2];
   wire bit_fall = ~clk_meta[1] & clk_meta[2];
   wire frame_end = (bit_cnt == CW'(FRAME_BITS - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_meta <= 3'h0;
         sdin_meta <= 2'h0;
         sdin_sync <= 2'h0;
      end else begin
         clk_meta <= {clk_meta[1:0], bit_clk};
         sdin_meta <= sdin;
         sdin_sync <= sdin_meta;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Parked on the last bit, so the first rise after reset opens a frame
         bit_cnt <= CW'(FRAME_BITS - 1);
         frame_sync <= 1'b0;
         tag_pending <= 1'b0;
      end else if (bit_rise) begin
         bit_cnt <= frame_end ? '0 : bit_cnt + CW'(1);
         frame_sync <= frame_end | (bit_cnt < CW'(TAG_BITS - 1));
         tag_pending <= frame_end;
      end else if (bit_fall) begin
         tag_pending <= 1'b0;
      end
   end

   // Codec ready is the first tag bit, taken on the falling bit clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ready_seen <= 2'h0;
         sdin_any <= 1'b0;
      end else begin
         ready_seen <= (bit_fall & tag_pending) ? sdin_sync : 2'h0;
         sdin_any <= |sdin_sync;
      end
   end
endmodule : alc_link_rx

// File: verilog/alc_link_ctrl.sv
// Purpose: Low-byte control of the audio codec link controller
// Assumes: AXI4-Lite slave, 32-bit data, control fields in byte lane 0
// Notes: Outputs are registered; link pins are sampled into aclk
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "alc_cfg.svh"
module alc_link_ctrl #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // AXI4-Lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output alc_pkg::alc_resp_t bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // AXI4-Lite read data
   output logic [31:0] rdata,
   output alc_pkg::alc_resp_t rresp,
   output logic rvalid,
   input wire logic rready,
   // Link pins
   input wire logic bit_clk,
   input wire logic [1:0] sdin,
   output logic sync,
   output logic sdout,
   output logic link_cold_reset_n,
   // Status toward the rest of the controller
   output logic receive_source_select,
   output logic link_wake_interrupt,
   output logic irq
);
   import alc_pkg::*;

   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] off);
      addr_is = (a[7:2] == off[7:2]);
   endfunction : addr_is

   alc_ctrl_t ctrl;
   logic [1:0] codec_ready;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic aw_got;
   logic w_got;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic frame_sync;
   logic [1:0] ready_seen;
   logic sdin_any;

   alc_link_rx u_link_rx (
      .aclk(aclk),
      .aresetn(aresetn),
      .bit_clk(bit_clk),
      .sdin(sdin),
      .frame_sync(frame_sync),
      .ready_seen(ready_seen),
      .sdin_any(sdin_any)
   );

   // Write channel: address and data taken in either order
   wire aw_hs = awvalid & awready;
   wire w_hs = wvalid & wready;
   wire aw_have = aw_got | aw_hs;
   wire w_have = w_got | w_hs;
   wire do_write = aw_have & w_have & ~bvalid;
   wire [ADDR_W-1:0] wr_addr = aw_got ? aw_addr_q : awaddr;
   wire [31:0] wr_data = w_got ? w_data_q : wdata;
   wire [3:0] wr_strb = w_got ? w_strb_q : wstrb;
   wire next_aw_got = aw_have & ~do_write;
   wire next_w_got = w_have & ~do_write;
   wire next_bvalid = do_write | (bvalid & ~bready);

   wire wr_hit_en = addr_is(wr_addr, `ALC_OFF_ENABLE);
   wire wr_hit_dis = addr_is(wr_addr, `ALC_OFF_DISABLE);
   wire wr_hit_rdy = addr_is(wr_addr, `ALC_OFF_READY);
   wire wr_hit_ist = addr_is(wr_addr, `ALC_OFF_IRQ_STATUS);
   wire wr_hit_msk = addr_is(wr_addr, `ALC_OFF_IRQ_MASK);
   wire wr_mapped = wr_hit_en | wr_hit_dis | wr_hit_rdy | wr_hit_ist
                  | wr_hit_msk;
   // Every field sits in byte lane 0; other lanes hold nothing
   wire wr_lane0 = do_write & wr_strb[0];
   wire [7:0] wb = wr_data[7:0];
   wire set_en = wr_lane0 & wr_hit_en;
   wire clr_en = wr_lane0 & wr_hit_dis;

   // Enable register: write-one-to-set; bits 7:5 have no storage
   alc_ctrl_t next_ctrl;
   assign next_ctrl.cold_release = ctrl.cold_release
      | (set_en & wb[`ALC_BIT_COLD_RELEASE]);
   assign next_ctrl.power_down = ctrl.power_down
      | (set_en & wb[`ALC_BIT_POWER_DOWN]);
   assign next_ctrl.wake_enable = ctrl.wake_enable
      | (set_en & wb[`ALC_BIT_WAKE_ENABLE]);
   // Disable register takes the same bit positions, write-one-to-clear
   assign next_ctrl.warm_reset = (ctrl.warm_reset
      | (set_en & wb[`ALC_BIT_WARM_RESET]))
      & ~(clr_en & wb[`ALC_BIT_WARM_RESET]);
   assign next_ctrl.rx_select = (ctrl.rx_select
      | (set_en & wb[`ALC_BIT_RX_SELECT]))
      & ~(clr_en & wb[`ALC_BIT_RX_SELECT]);

   // Ready clear is a strobe; a flag arriving the same cycle still sets
   wire ready_clear = set_en & wb[`ALC_BIT_READY_CLEAR];
   wire [1:0] next_codec_ready =
      (codec_ready & {2{~ready_clear}}) | ready_seen;

   wire wake_level = ctrl.wake_enable & sdin_any;
   wire [2:0] irq_event = {wake_level, ready_seen};
   wire [2:0] irq_w1c = (wr_lane0 & wr_hit_ist) ? wb[2:0] : 3'h0;
   wire [2:0] next_irq_status = (irq_status & ~irq_w1c) | irq_event;
   wire [2:0] next_irq_mask = (wr_lane0 & wr_hit_msk) ? wb[2:0] : irq_mask;

   // Link outputs: warm reset holds sync high even over power down; power down otherwise forces low
   wire next_sync = ctrl.warm_reset
      | (frame_sync & ~ctrl.power_down & ctrl.cold_release);

   // Read channel
   wire ar_hs = arvalid & arready;
   wire next_rvalid = ar_hs | (rvalid & ~rready);
   wire rd_hit_en = addr_is(araddr, `ALC_OFF_ENABLE);
   wire rd_hit_rdy = addr_is(araddr, `ALC_OFF_READY);
   wire rd_hit_ist = addr_is(araddr, `ALC_OFF_IRQ_STATUS);
   wire rd_hit_msk = addr_is(araddr, `ALC_OFF_IRQ_MASK);
   wire rd_hit_dis = addr_is(araddr, `ALC_OFF_DISABLE);
   wire rd_mapped = rd_hit_en | rd_hit_rdy | rd_hit_ist | rd_hit_msk
                  | rd_hit_dis;
   // Bits 7:5 of the enable image read zero
   wire [31:0] rd_value =
        rd_hit_en ? {27'h000_0000, ctrl}
      : rd_hit_rdy ? {30'h0000_0000, codec_ready}
      : rd_hit_ist ? {29'h0000_0000, irq_status}
      : rd_hit_msk ? {29'h0000_0000, irq_mask}
      : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `ALC_RESP_OKAY;
      end else begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         awready <= ~next_aw_got & ~next_bvalid;
         wready <= ~next_w_got & ~next_bvalid;
         bvalid <= next_bvalid;
         if (do_write) begin
            bresp <= wr_mapped ? `ALC_RESP_OKAY : `ALC_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (aw_hs) begin
         aw_addr_q <= awaddr;
      end
      if (w_hs) begin
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `ALC_RESP_OKAY;
      end else begin
         arready <= ~next_rvalid;
         rvalid <= next_rvalid;
         if (ar_hs) begin
            rdata <= rd_value;
            rresp <= rd_mapped ? `ALC_RESP_OKAY : `ALC_RESP_SLVERR;
         end
      end
   end

   // Cold reset stays asserted from chip reset until software releases
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= `ALC_CTRL_RESET;
         codec_ready <= 2'h0;
         irq_status <= `ALC_IRQ_RESET;
         irq_mask <= `ALC_IRQ_RESET;
         sync <= 1'b0;
         sdout <= 1'b0;
         link_cold_reset_n <= 1'b0;
         receive_source_select <= 1'b0;
         link_wake_interrupt <= 1'b0;
         irq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         codec_ready <= next_codec_ready;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         sync <= next_sync;
         // No slot payload here, so serial out idles low
         sdout <= 1'b0;
         link_cold_reset_n <= ctrl.cold_release;
         receive_source_select <= ctrl.rx_select;
         link_wake_interrupt <= wake_level;
         irq <= |(irq_status & irq_mask);
      end
   end
endmodule : alc_link_ctrl

// File: verif/alc_link_ctrl_assertions.sv
// Purpose: Port-level checks of the link control block
// Assumes: Bound to alc_link_ctrl, one write at a time
// Notes: Captured write fields tie pin changes to their cause
`timescale 1ns/100ps
`include "alc_cfg.svh"
module alc_ctrl_chk #(
   parameter int ADDR_W = 8
) (
   // Clock, reset and register bus
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   // Link and status
   input wire logic [1:0] sdin,
   input wire logic sync,
   input wire logic sdout,
   input wire logic link_cold_reset_n,
   input wire logic receive_source_select,
   input wire logic link_wake_interrupt
);
   logic [ADDR_W-1:0] wa;
   logic [7:0] wd;
   logic on_en;
   logic on_dis;
   assign on_en = wa == ADDR_W'(`ALC_OFF_ENABLE);
   assign on_dis = wa == ADDR_W'(`ALC_OFF_DISABLE);
   always_ff @(posedge aclk) begin
      if (awvalid && awready) wa <= awaddr;
      if (wvalid && wready) wd <= wdata[7:0];
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_cold_release: assert property (
      $rose(bvalid) && on_en && wd[0] |-> ##[1:2] link_cold_reset_n)
      else $error("cold reset not released");
   chk_cold_sticky: assert property (
      link_cold_reset_n |=> link_cold_reset_n)
      else $error("cold reset fell again");
   chk_rx_set: assert property (
      $rose(bvalid) && on_en && wd[4] |-> ##[0:2] receive_source_select)
      else $error("slot 6 not selected");
   chk_rx_clear: assert property (
      $rose(bvalid) && on_dis && wd[4] |-> ##[0:2] !receive_source_select)
      else $error("slots 3 and 4 not selected");
   chk_rx_cause: assert property (
      $changed(receive_source_select) |-> bvalid || $past(bvalid))
      else $error("source changed without a write");
   chk_warm_sync: assert property (
      $rose(bvalid) && on_en && wd[3] && link_cold_reset_n |-> ##[1:3] sync)
      else $error("warm reset not on sync");
   chk_wake_cause: assert property (
      link_wake_interrupt |-> $past(sdin, 2) != 0 || $past(sdin, 3) != 0
         || $past(sdin, 4) != 0 || $past(sdin, 5) != 0)
      else $error("wake without high data");
   chk_sdout_low: assert property (sdout == 1'b0)
      else $error("serial out not low");
   chk_reserved_zero: assert property (rvalid |-> rdata[7:6] == 2'b00)
      else $error("reserved bits not zero");
   chk_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   cov_wake: cover property (link_wake_interrupt);
   cov_source: cover property ($rose(receive_source_select));
   cov_release: cover property ($rose(link_cold_reset_n));
endmodule : alc_ctrl_chk
bind alc_link_ctrl alc_ctrl_chk #(.ADDR_W(ADDR_W)) chk_u (
   .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
   .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
   .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rvalid(rvalid), .sdin(sdin), .sync(sync), .sdout(sdout),
   .link_cold_reset_n(link_cold_reset_n),
   .receive_source_select(receive_source_select),
   .link_wake_interrupt(link_wake_interrupt));

// File: verif/alc_codec_model.sv
// Purpose: Behavioural codec on the far side of the link
// Assumes: Bit clock starts a frame when the bench asks and runs all 256 bits
// Notes: Wake request is data held high with the clock stopped
`timescale 1ns/100ps
module alc_codec_model (
   // From the controller and the bench
   input wire logic link_cold_reset_n,
   input wire logic frame_go,
   input wire logic [1:0] ready_bits,
   input wire logic [1:0] wake_level,
   // Link toward the controller
   output logic bit_clk,
   output logic [1:0] sdin
);
   int k;
   initial begin
      bit_clk = 1'b0;
      sdin = 2'b00;
      forever begin
         // Clock stopped while held in cold reset; data follows the wake level
         // Unknown inputs at time zero must not start a frame
         while (frame_go !== 1'b1 || link_cold_reset_n !== 1'b1) begin
            sdin = wake_level;
            #8;
         end
         for (k = 0; k < 256; k++) begin
            #62.5 bit_clk = 1'b1;
            // Ready flags ride in the tag slot only
            sdin = (k < 16) ? ready_bits : 2'b00;
            #62.5 bit_clk = 1'b0;
         end
      end
   end
endmodule : alc_codec_model

// File: verif/alc_link_ctrl_test.sv
// Purpose: Self-checking bench of the link control block
// Assumes: Codec model makes the bit clock and serial data
// Notes: Software hold times are kept by the waits here
`timescale 1ns/100ps
`include "alc_cfg.svh"
module alc_link_ctrl_test;
   import alc_pkg::*;
   localparam logic [7:0] EN = `ALC_OFF_ENABLE, DIS = `ALC_OFF_DISABLE;
   localparam logic [7:0] RDY = `ALC_OFF_READY, ST = `ALC_OFF_IRQ_STATUS;
   localparam logic [7:0] MSK = `ALC_OFF_IRQ_MASK;
   localparam alc_resp_t OK = `ALC_RESP_OKAY, ERR = `ALC_RESP_SLVERR;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, frame_go;
   logic awready, wready, bvalid, arready, rvalid, bit_clk, sync, sdout;
   logic link_cold_reset_n, receive_source_select, link_wake_interrupt, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] sdin, ready_bits, wake_level;
   alc_resp_t bresp, rresp;
   int n_errors = 0;
   int n_tests = 0;
   int n;
   alc_link_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .bit_clk(bit_clk), .sdin(sdin), .sync(sync),
      .sdout(sdout), .link_cold_reset_n(link_cold_reset_n),
      .receive_source_select(receive_source_select),
      .link_wake_interrupt(link_wake_interrupt), .irq(irq));
   alc_codec_model codec_u (.link_cold_reset_n(link_cold_reset_n),
      .frame_go(frame_go), .ready_bits(ready_bits),
      .wake_level(wake_level), .bit_clk(bit_clk), .sdin(sdin));
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp_word
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask : cmp_bit
   task automatic hang(input int c);
      if (c >= 40) begin
         n_errors++;
         $display("[FAIL] %0t no bus answer", $time);
         report_and_stop();
      end
   endtask : hang
   task automatic idle(input int c);
      repeat (c) @(posedge aclk);
   endtask : idle
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input alc_resp_t er);
      int c;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (c = 0; c < 40; c++) begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      hang(c);
      cmp_word({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
      input alc_resp_t er);
      int c;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (c = 0; c < 40; c++) begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      hang(c);
      cmp_word(rdata, ed);
      cmp_word({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic t_cold();
      rd(EN, 32'h0000_0000, OK);
      cmp_bit(link_cold_reset_n, 1'b0);
      rd(8'h14, 32'h0000_0000, ERR);
      wr(8'h14, 32'h0000_001F, ERR);
      idle(125);
      wr(EN, 32'h0000_0001, OK);
      rd(EN, 32'h0000_0001, OK);
      cmp_bit(link_cold_reset_n, 1'b1);
   endtask : t_cold
   task automatic t_source();
      wr(EN, 32'h0000_0010, OK);
      wr(EN, 32'h0000_00C0, OK);
      rd(EN, 32'h0000_0011, OK);
      cmp_bit(receive_source_select, 1'b1);
      wr(DIS, 32'h0000_0010, OK);
      rd(DIS, 32'h0000_0000, OK);
      rd(EN, 32'h0000_0001, OK);
      cmp_bit(receive_source_select, 1'b0);
   endtask : t_source
   task automatic t_warm();
      wr(EN, 32'h0000_0008, OK);
      rd(EN, 32'h0000_0009, OK);
      cmp_bit(sync, 1'b1);
      idle(125);
      wr(DIS, 32'h0000_0008, OK);
      rd(EN, 32'h0000_0001, OK);
      cmp_bit(sync, 1'b0);
   endtask : t_warm
   task automatic t_ready();
      wr(MSK, 32'h0000_0003, OK);
      ready_bits <= 2'b10;
      frame_go <= 1'b1;
      idle(100);
      frame_go <= 1'b0;
      idle(4100);
      rd(RDY, 32'h0000_0002, OK);
      cmp_bit(irq, 1'b1);
      wr(EN, 32'h0000_0001, OK);
      rd(RDY, 32'h0000_0002, OK);
   endtask : t_ready
   task automatic t_power();
      ready_bits <= 2'b00;
      wr(EN, 32'h0000_0002, OK);
      rd(EN, 32'h0000_0003, OK);
      frame_go <= 1'b1;
      for (n = 0; n < 64; n++) begin
         idle(8);
         cmp_bit(sync | sdout, 1'b0);
      end
      frame_go <= 1'b0;
      idle(4100);
      wr(EN, 32'h0000_0020, OK);
      rd(RDY, 32'h0000_0000, OK);
      rd(EN, 32'h0000_0003, OK);
      wr(ST, 32'h0000_0003, OK);
      cmp_bit(irq, 1'b0);
   endtask : t_power
   task automatic t_wake();
      wr(EN, 32'h0000_0004, OK);
      rd(EN, 32'h0000_0007, OK);
      cmp_bit(link_wake_interrupt, 1'b0);
      wake_level <= 2'b01;
      idle(10);
      cmp_bit(link_wake_interrupt, 1'b1);
      cmp_bit(irq, 1'b0);
      wr(MSK, 32'h0000_0004, OK);
      cmp_bit(irq, 1'b1);
      wake_level <= 2'b00;
      idle(10);
      cmp_bit(link_wake_interrupt, 1'b0);
      wr(ST, 32'h0000_0004, OK);
      cmp_bit(irq, 1'b0);
   endtask : t_wake
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata} = 48'h0000_0000_0000;
      {frame_go, ready_bits, wake_level} = 5'h00;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_cold();
      t_source();
      t_warm();
      t_ready();
      t_power();
      t_wake();
      report_and_stop();
   end
endmodule : alc_link_ctrl_test
